// ---- card_irq_pkg.sv ----
/*
  Shared constants and types of the card interrupt event block: register
  offsets, field positions, reset values, card types and signalling modes.
  Assumes a single host clock domain and a simple byte-addressed register port.
*/
package card_irq_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_LEGACY_STATUS = 8'h04;
  localparam logic [7:0] OFS_LEGACY_MASK = 8'h05;
  localparam logic [7:0] OFS_LEGACY_GLOBAL = 8'h1E;
  localparam logic [7:0] OFS_ROUTING = 8'h8C;
  localparam logic [7:0] OFS_CARD_CONTROL = 8'h91;
  localparam logic [7:0] OFS_DEVICE_CONTROL = 8'h92;
  localparam logic [7:0] OFS_SOCKET_EVENT = 8'hA0;
  localparam logic [7:0] OFS_SOCKET_MASK = 8'hA4;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int LEG_BATT_A = 0;
  localparam int LEG_BATT_B = 1;
  localparam int LEG_READY = 2;
  localparam int LEG_POWER = 3;
  localparam int LEG_DETECT = 4;
  localparam int SOCK_STATUS = 0;
  localparam int SOCK_DETECT_A = 1;
  localparam int SOCK_DETECT_B = 2;
  localparam int SOCK_POWER = 3;
  localparam int GLOBAL_FLAG_CLEAR_SELECT = 2;
  localparam int CARD_CONTROL_FUNC = 0;
  localparam int DEVCTL_MODE_LSB = 1;
  localparam int DEVCTL_FUNC_ON_INTB = 3;
  localparam int ROUTE_FUNC_LSB = 0;
  localparam int ROUTE_CSC_LSB = 4;
  localparam int PIN_COUNT = 7;

  // ----------------------------------------------------------------------
  // Reset values and implemented-bit masks
  // ----------------------------------------------------------------------
  localparam logic [7:0] LEGACY_RESET = 8'h00;
  localparam logic [7:0] LEGACY_BITS = 8'h1F;
  localparam logic [31:0] SOCKET_RESET = 32'h0000_0000;
  localparam logic [31:0] SOCKET_BITS = 32'h0000_000F;
  localparam logic [7:0] GLOBAL_RESET = 8'h00;
  localparam logic [31:0] ROUTING_RESET = 32'h0000_0077;
  localparam logic [7:0] DEVCTL_RESET = 8'h00;
  localparam logic [7:0] CARD_CONTROL_RESET = 8'h00;
  localparam logic [2:0] ROUTE_NONE = 3'h7;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    CARD_MEMORY = 2'b00,
    CARD_IO = 2'b01,
    CARD_BUS = 2'b10,
    CARD_EMPTY = 2'b11
  } card_kind_type;

  typedef enum logic [1:0] {
    MODE_PCI_ONLY = 2'b00,
    MODE_PARALLEL_IRQ = 2'b01,
    MODE_SERIAL_IRQ = 2'b10,
    MODE_RESERVED = 2'b11
  } signal_mode_type;

  // Shared socket pins, named by their 16-bit memory card meaning.
  typedef struct packed {
    logic battery_detect_a;
    logic battery_detect_b;
    logic ready;
    logic card_detect_a;
    logic card_detect_b;
  } card_pins_type;

  localparam int CARD_PIN_WIDTH = 5;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [31:0] wdata;
  } reg_req_type;

endpackage : card_irq_pkg

// ---- pin_sync.sv ----
/*
  Three-stage synchroniser with agreement filter for one socket pin.
  Assumes the pin is asynchronous to CLK_SYS; the first stage feeds only
  the second.
*/
module pin_sync (
  // Clock, reset and enable
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  // Pin and result
  input wire logic pin,
  output logic level,
  output logic changed
);

  logic meta_reg;
  logic sync2_reg;
  logic sync3_reg;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
    end else if (ce) begin
      meta_reg <= pin;
      sync2_reg <= meta_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // A change is taken only once stages two and three agree on it.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      level <= 1'b0;
      changed <= 1'b0;
    end else if (ce) begin
      changed <= (sync2_reg == sync3_reg) && (sync3_reg != level);
      if (sync2_reg == sync3_reg) begin
        level <= sync3_reg;
      end
    end
  end

endmodule : pin_sync

// ---- card_interrupt_events.sv ----
/*
  Card socket interrupt event block: detects status change and functional
  interrupt events, latches status changes in flag registers, masks them and signals
  the host on PCI interrupt lines, routed multipurpose pins or a serial
  interrupt request pair.
  Assumes socket pins are asynchronous, while card type, power-up done and
  the register port are synchronous to CLK_SYS.
*/
// Notes on behaviour
// - Each event is status change or functional
// - PCI, parallel IRQ or serial signalling modes
// - Seven multipurpose pins plus INTA and INTB
// - Memory card battery line changes flag bits 1,0
// - Memory card ready change flags bit 2
// - I/O card status-change line assertion flags legacy bit 0
// - I/O card request unmaskable, shown at 91h
// - CardBus request always enabled, shown at 91h
// - CardBus status-change flags socket event bit 0
// - Card detect changes flag socket bits 2,1
// - Power-up completion flags bit 3
// - No functional requests for memory cards
// - Shared pins read per inserted card type
// - Legacy set for 16-bit, socket set CardBus; card detect sets both for any type
// - Legacy flags clear on read or write-one
// - Socket event flags clear on write-one
module card_interrupt_events (
  // Clock, reset and enable
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  input wire logic CE,
  // Socket side
  input wire card_irq_pkg::card_pins_type CARD_PINS,
  input wire card_irq_pkg::card_kind_type CARD_TYPE,
  input wire logic POWER_UP_DONE,
  // Register port
  input wire card_irq_pkg::reg_req_type REG_REQ,
  output logic [31:0] REG_RDATA,
  output logic REG_RVALID,
  // Host interrupt signalling
  output logic PCI_INTA_N,
  output logic PCI_INTB_N,
  output logic [6:0] MULTIPURPOSE_PIN_O,
  output logic [6:0] MULTIPURPOSE_PIN_OE,
  output logic SERIAL_IRQ_CSC,
  output logic SERIAL_IRQ_FUNC
);

  // ----------------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------------
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction : hit

  function automatic logic is_16bit(input card_irq_pkg::card_kind_type kind);
    is_16bit = (kind == card_irq_pkg::CARD_MEMORY) || (kind == card_irq_pkg::CARD_IO);
  endfunction : is_16bit

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [card_irq_pkg::CARD_PIN_WIDTH-1:0] pin_raw;
  logic [card_irq_pkg::CARD_PIN_WIDTH-1:0] pin_level;
  logic [card_irq_pkg::CARD_PIN_WIDTH-1:0] pin_changed;
  card_irq_pkg::card_pins_type lvl;
  card_irq_pkg::card_pins_type chg;

  assign pin_raw = CARD_PINS;
  assign lvl = pin_level;
  assign chg = pin_changed;

  genvar gi;
  generate
    for (gi = 0; gi < card_irq_pkg::CARD_PIN_WIDTH; gi++) begin : g_sync
      pin_sync u_sync (
        .clk(CLK_SYS),
        .arst_n(ARST_N),
        .ce(CE),
        .pin(pin_raw[gi]),
        .level(pin_level[gi]),
        .changed(pin_changed[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Event classification by card type
  // ----------------------------------------------------------------------
  logic [7:0] legacy_set;
  logic [31:0] socket_set;
  logic status_line_assert;
  logic func_request;

  // The battery-a pin doubles as the status-change line on I/O and CardBus cards.
  assign status_line_assert = chg.battery_detect_a && lvl.battery_detect_a;

  always_comb begin
    legacy_set = 8'h00;
    socket_set = 32'h0000_0000;
    case (CARD_TYPE)
      card_irq_pkg::CARD_MEMORY: begin
        legacy_set[card_irq_pkg::LEG_BATT_A] = chg.battery_detect_a;
        legacy_set[card_irq_pkg::LEG_BATT_B] = chg.battery_detect_b;
        legacy_set[card_irq_pkg::LEG_READY] = chg.ready;
      end
      card_irq_pkg::CARD_IO: begin
        legacy_set[card_irq_pkg::LEG_BATT_A] = status_line_assert;
      end
      card_irq_pkg::CARD_BUS: begin
        socket_set[card_irq_pkg::SOCK_STATUS] = status_line_assert;
      end
      default: begin
        legacy_set = 8'h00;
      end
    endcase
    // Insertion and removal are reported whatever the type.
    socket_set[card_irq_pkg::SOCK_DETECT_A] = chg.card_detect_a;
    socket_set[card_irq_pkg::SOCK_DETECT_B] = chg.card_detect_b;
    legacy_set[card_irq_pkg::LEG_DETECT] = chg.card_detect_a || chg.card_detect_b;
    if (POWER_UP_DONE) begin
      if (CARD_TYPE == card_irq_pkg::CARD_BUS) begin
        socket_set[card_irq_pkg::SOCK_POWER] = 1'b1;
      end else if (is_16bit(CARD_TYPE)) begin
        legacy_set[card_irq_pkg::LEG_POWER] = 1'b1;
      end
    end
  end

  // Functional requests are a level; a memory card never produces one.
  assign func_request = lvl.ready &&
    ((CARD_TYPE == card_irq_pkg::CARD_IO) || (CARD_TYPE == card_irq_pkg::CARD_BUS));

  // ----------------------------------------------------------------------
  // Register port decode
  // ----------------------------------------------------------------------
  logic wr_legacy_status;
  logic rd_legacy_status;
  logic wr_socket_event;
  logic flag_clear_by_write;
  logic [7:0] legacy_status_reg;
  logic [7:0] legacy_mask_reg;
  logic [7:0] global_ctrl_reg;
  logic [31:0] routing_reg;
  logic [7:0] device_ctrl_reg;
  logic [7:0] card_control_reg;
  logic [31:0] socket_event_reg;
  logic [31:0] socket_mask_reg;

  assign wr_legacy_status = REG_REQ.wr && hit(REG_REQ.addr, card_irq_pkg::OFS_LEGACY_STATUS);
  assign rd_legacy_status = REG_REQ.rd && hit(REG_REQ.addr, card_irq_pkg::OFS_LEGACY_STATUS);
  assign wr_socket_event = REG_REQ.wr && hit(REG_REQ.addr, card_irq_pkg::OFS_SOCKET_EVENT);
  assign flag_clear_by_write = global_ctrl_reg[card_irq_pkg::GLOBAL_FLAG_CLEAR_SELECT];

  // ----------------------------------------------------------------------
  // Legacy flags: a new event always beats a clear in the same cycle
  // ----------------------------------------------------------------------
  logic [7:0] legacy_clear;

  always_comb begin
    legacy_clear = 8'h00;
    if (flag_clear_by_write && wr_legacy_status) begin
      legacy_clear = REG_REQ.wdata[7:0];
    end else if (!flag_clear_by_write && rd_legacy_status) begin
      legacy_clear = 8'hFF;
    end
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      legacy_status_reg <= card_irq_pkg::LEGACY_RESET;
    end else if (CE) begin
      legacy_status_reg <= ((legacy_status_reg & ~legacy_clear) | legacy_set) & card_irq_pkg::LEGACY_BITS;
    end
  end

  // ----------------------------------------------------------------------
  // Socket event flags
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      socket_event_reg <= card_irq_pkg::SOCKET_RESET;
    end else if (CE) begin
      socket_event_reg <= ((socket_event_reg & ~(wr_socket_event ? REG_REQ.wdata : 32'h0000_0000))
        | socket_set) & card_irq_pkg::SOCKET_BITS;
    end
  end

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      legacy_mask_reg <= card_irq_pkg::LEGACY_RESET;
      global_ctrl_reg <= card_irq_pkg::GLOBAL_RESET;
      routing_reg <= card_irq_pkg::ROUTING_RESET;
      device_ctrl_reg <= card_irq_pkg::DEVCTL_RESET;
      card_control_reg <= card_irq_pkg::CARD_CONTROL_RESET;
      socket_mask_reg <= card_irq_pkg::SOCKET_RESET;
    end else if (CE && REG_REQ.wr) begin
      if (hit(REG_REQ.addr, card_irq_pkg::OFS_LEGACY_MASK)) begin
        legacy_mask_reg <= REG_REQ.wdata[7:0] & card_irq_pkg::LEGACY_BITS;
      end
      if (hit(REG_REQ.addr, card_irq_pkg::OFS_LEGACY_GLOBAL)) begin
        global_ctrl_reg <= REG_REQ.wdata[7:0];
      end
      if (hit(REG_REQ.addr, card_irq_pkg::OFS_ROUTING)) begin
        routing_reg <= REG_REQ.wdata;
      end
      if (hit(REG_REQ.addr, card_irq_pkg::OFS_DEVICE_CONTROL)) begin
        device_ctrl_reg <= REG_REQ.wdata[7:0];
      end
      if (hit(REG_REQ.addr, card_irq_pkg::OFS_CARD_CONTROL)) begin
        card_control_reg <= {REG_REQ.wdata[7:1], 1'b0};
      end
      if (hit(REG_REQ.addr, card_irq_pkg::OFS_SOCKET_MASK)) begin
        socket_mask_reg <= REG_REQ.wdata & card_irq_pkg::SOCKET_BITS;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  logic [31:0] rdata_next;
  logic [7:0] card_control_view;

  // Bit 0 shows the live functional request; it has no mask and no clear.
  assign card_control_view = {card_control_reg[7:1], func_request};

  always_comb begin
    rdata_next = 32'h0000_0000;
    case (REG_REQ.addr)
      card_irq_pkg::OFS_LEGACY_STATUS: rdata_next = {24'h00_0000, legacy_status_reg};
      card_irq_pkg::OFS_LEGACY_MASK: rdata_next = {24'h00_0000, legacy_mask_reg};
      card_irq_pkg::OFS_LEGACY_GLOBAL: rdata_next = {24'h00_0000, global_ctrl_reg};
      card_irq_pkg::OFS_ROUTING: rdata_next = routing_reg;
      card_irq_pkg::OFS_CARD_CONTROL: rdata_next = {24'h00_0000, card_control_view};
      card_irq_pkg::OFS_DEVICE_CONTROL: rdata_next = {24'h00_0000, device_ctrl_reg};
      card_irq_pkg::OFS_SOCKET_EVENT: rdata_next = socket_event_reg;
      card_irq_pkg::OFS_SOCKET_MASK: rdata_next = socket_mask_reg;
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      REG_RDATA <= 32'h0000_0000;
      REG_RVALID <= 1'b0;
    end else if (CE) begin
      REG_RVALID <= REG_REQ.rd;
      if (REG_REQ.rd) begin
        REG_RDATA <= rdata_next;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt requests
  // ----------------------------------------------------------------------
  logic csc_request;
  card_irq_pkg::signal_mode_type mode;
  logic [2:0] func_pin_sel;
  logic [2:0] csc_pin_sel;
  logic func_on_intb;

  assign csc_request = |(legacy_status_reg & legacy_mask_reg)
    || |(socket_event_reg & socket_mask_reg);
  assign mode = card_irq_pkg::signal_mode_type'(device_ctrl_reg[card_irq_pkg::DEVCTL_MODE_LSB +: 2]);
  assign func_pin_sel = routing_reg[card_irq_pkg::ROUTE_FUNC_LSB +: 3];
  assign csc_pin_sel = routing_reg[card_irq_pkg::ROUTE_CSC_LSB +: 3];
  assign func_on_intb = device_ctrl_reg[card_irq_pkg::DEVCTL_FUNC_ON_INTB];

  // ----------------------------------------------------------------------
  // Signalling outputs
  // ----------------------------------------------------------------------
  // INTA always carries status changes; functional requests use INTA or INTB
  // only in the PCI-only mode.
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      PCI_INTA_N <= 1'b1;
      PCI_INTB_N <= 1'b1;
      SERIAL_IRQ_CSC <= 1'b0;
      SERIAL_IRQ_FUNC <= 1'b0;
    end else if (CE) begin
      PCI_INTA_N <= !(csc_request ||
        (func_request && !func_on_intb && (mode == card_irq_pkg::MODE_PCI_ONLY)));
      PCI_INTB_N <= !(func_request && func_on_intb && (mode == card_irq_pkg::MODE_PCI_ONLY));
      SERIAL_IRQ_CSC <= csc_request && (mode == card_irq_pkg::MODE_SERIAL_IRQ);
      SERIAL_IRQ_FUNC <= func_request && (mode == card_irq_pkg::MODE_SERIAL_IRQ);
    end
  end

  generate
    for (gi = 0; gi < card_irq_pkg::PIN_COUNT; gi++) begin : g_pin
      logic func_here;
      logic csc_here;
      assign func_here = (func_pin_sel == 3'(gi));
      assign csc_here = (csc_pin_sel == 3'(gi));
      always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
          MULTIPURPOSE_PIN_O[gi] <= 1'b0;
          MULTIPURPOSE_PIN_OE[gi] <= 1'b0;
        end else if (CE) begin
          MULTIPURPOSE_PIN_OE[gi] <= (mode == card_irq_pkg::MODE_PARALLEL_IRQ) && (func_here || csc_here);
          MULTIPURPOSE_PIN_O[gi] <= (mode == card_irq_pkg::MODE_PARALLEL_IRQ) &&
            ((func_here && func_request) || (csc_here && csc_request));
        end
      end
    end
  endgenerate

endmodule : card_interrupt_events

// ---- card_interrupt_events_monitor.sv ----
/*
  Checker for the card interrupt event block: port-level timing relations.
  Assumes one clock domain and attachment by bind from the testbench.
*/
module card_interrupt_events_monitor (
  // Clock, reset and enable
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  input wire logic CE,
  // Socket side and register port
  input wire card_irq_pkg::card_kind_type CARD_TYPE,
  input wire card_irq_pkg::reg_req_type REG_REQ,
  input wire logic [31:0] REG_RDATA,
  input wire logic REG_RVALID,
  // Host signalling
  input wire logic PCI_INTA_N,
  input wire logic [6:0] MULTIPURPOSE_PIN_O,
  input wire logic [6:0] MULTIPURPOSE_PIN_OE,
  input wire logic SERIAL_IRQ_CSC,
  input wire logic SERIAL_IRQ_FUNC
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!ARST_N);

  // --------------------------------------------------------------------
  // Sequences and properties
  // --------------------------------------------------------------------
  sequence s_rd_taken;
    CE && REG_REQ.rd;
  endsequence
  sequence s_rd_at(logic [7:0] a);
    CE && REG_REQ.rd && REG_REQ.addr == a;
  endsequence
  sequence s_pulse_once;
    REG_RVALID ##1 !REG_RVALID;
  endsequence

  property p_read_answer;
    s_rd_taken ##1 (CE && !REG_REQ.rd) |-> s_pulse_once;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("Read answer pulse missing or too long");
  property p_no_spurious_rvalid;
    REG_RVALID && $past(CE) |-> $past(REG_REQ.rd);
  endproperty
  a_no_spurious_rvalid: assert property (p_no_spurious_rvalid)
    else $error("Read answer without a read");
  property p_unmapped_zero;
    s_rd_at(8'h10) |=> REG_RDATA == 32'h0000_0000;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("Unmapped read not zero");
  property p_legacy_width;
    s_rd_at(card_irq_pkg::OFS_LEGACY_STATUS) |=> REG_RDATA[31:5] == 27'h0;
  endproperty
  a_legacy_width: assert property (p_legacy_width)
    else $error("Legacy status has bits above bit 4");
  property p_socket_width;
    s_rd_at(card_irq_pkg::OFS_SOCKET_EVENT) |=> REG_RDATA[31:4] == 28'h0;
  endproperty
  a_socket_width: assert property (p_socket_width)
    else $error("Socket event has bits above bit 3");
  property p_memory_no_func;
    CARD_TYPE == card_irq_pkg::CARD_MEMORY && $past(CARD_TYPE) == card_irq_pkg::CARD_MEMORY
      && $past(CARD_TYPE, 2) == card_irq_pkg::CARD_MEMORY |-> !SERIAL_IRQ_FUNC;
  endproperty
  a_memory_no_func: assert property (p_memory_no_func)
    else $error("Functional request with memory card");
  property p_serial_csc_inta;
    SERIAL_IRQ_CSC |-> !PCI_INTA_N;
  endproperty
  a_serial_csc_inta: assert property (p_serial_csc_inta)
    else $error("Status change not on INTA");
  property p_pin_enable;
    (MULTIPURPOSE_PIN_O & ~MULTIPURPOSE_PIN_OE) == 7'h00;
  endproperty
  a_pin_enable: assert property (p_pin_enable)
    else $error("Multipurpose pin level without enable");
  property p_freeze;
    !CE |=> $stable(PCI_INTA_N) && $stable(REG_RVALID) && $stable(REG_RDATA);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("Outputs moved while disabled");
endmodule : card_interrupt_events_monitor

// ---- card_socket_model.sv ----
/*
  Behavioural card socket: pins, card type and power-up completion pulse.
  Assumes the bench requests changes; outputs move just after CLK edges.
*/
module card_socket_model #(
  parameter int POWER_DELAY = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Requests from the bench
  input wire card_irq_pkg::card_pins_type want_pins,
  input wire card_irq_pkg::card_kind_type want_kind,
  input wire logic power_req,
  // Socket outputs
  output card_irq_pkg::card_pins_type pins,
  output card_irq_pkg::card_kind_type kind,
  output logic power_done
);
  timeunit 1ns;
  timeprecision 1ps;
  int count_reg;
  logic power_req_reg;

  // Pins change one edge after the request, never at the sampling instant.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pins <= '0;
      kind <= card_irq_pkg::CARD_MEMORY;
    end else begin
      pins <= want_pins;
      kind <= want_kind;
    end
  end

  // The socket power sequence takes a while, then reports once.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count_reg <= 0;
      power_req_reg <= 1'b0;
      power_done <= 1'b0;
    end else begin
      power_req_reg <= power_req;
      power_done <= (count_reg == 1);
      if (power_req && !power_req_reg) begin
        count_reg <= POWER_DELAY;
      end else if (count_reg != 0) begin
        count_reg <= count_reg - 1;
      end
    end
  end
endmodule : card_socket_model

// ---- tb_card_interrupt_events.sv ----
/*
  Self-checking testbench of the card interrupt event block.
  Assumes the package, socket model and checker are compiled before it.
*/
module tb_card_interrupt_events;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic ce = 1'b1;
  logic power_req = 1'b0;
  card_irq_pkg::card_pins_type want_pins = '0;
  card_irq_pkg::card_kind_type want_kind = card_irq_pkg::CARD_MEMORY;
  card_irq_pkg::reg_req_type req = '0;
  card_irq_pkg::card_pins_type pins;
  card_irq_pkg::card_kind_type kind;
  logic power_done, rvalid, inta_n, intb_n, ser_csc, ser_func;
  logic [6:0] mp_o, mp_oe;
  logic [31:0] rdata, rd_val;
  logic [7:0] zero_ofs [7] = '{8'h04, 8'h05, 8'h1E, 8'h91, 8'h92, 8'hA0, 8'hA4};
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;

  always #12.5 clk = ~clk;

  card_socket_model socket_u (.clk(clk), .arst_n(arst_n), .want_pins(want_pins), .want_kind(want_kind),
    .power_req(power_req), .pins(pins), .kind(kind), .power_done(power_done));
  card_interrupt_events dut_u (.CLK_SYS(clk), .ARST_N(arst_n), .CE(ce), .CARD_PINS(pins), .CARD_TYPE(kind),
    .POWER_UP_DONE(power_done), .REG_REQ(req), .REG_RDATA(rdata), .REG_RVALID(rvalid), .PCI_INTA_N(inta_n),
    .PCI_INTB_N(intb_n), .MULTIPURPOSE_PIN_O(mp_o), .MULTIPURPOSE_PIN_OE(mp_oe), .SERIAL_IRQ_CSC(ser_csc),
    .SERIAL_IRQ_FUNC(ser_func));

  // --------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------
  function automatic logic [31:0] ext1(input logic v);
    return {31'h0, v};
  endfunction : ext1
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : idle
  task automatic reg_rd(input logic [7:0] a);
    @(posedge clk);
    req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 32'h0};
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    check(ext1(rvalid), 32'h1);
    rd_val = rdata;
  endtask : reg_rd
  task automatic expect_rd(input logic [7:0] a, input logic [31:0] exp);
    reg_rd(a);
    check(rd_val, exp);
  endtask : expect_rd
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask : reg_wr
  task automatic drive(input card_irq_pkg::card_kind_type k, input logic [4:0] p);
    @(posedge clk);
    want_kind <= k;
    want_pins <= card_irq_pkg::card_pins_type'(p);
    idle(9);
  endtask : drive
  task automatic pwr();
    @(posedge clk);
    power_req <= 1'b1;
    @(posedge clk);
    power_req <= 1'b0;
    idle(9);
  endtask : pwr

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task automatic t_reset();
    foreach (zero_ofs[i]) expect_rd(zero_ofs[i], 32'h0);
    expect_rd(8'h8C, 32'h77);
    expect_rd(8'h10, 32'h0);
    @(posedge clk);
    ce <= 1'b0;
    req.rd <= 1'b1;
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    check(ext1(rvalid), 32'h0);
    @(posedge clk);
    ce <= 1'b1;
    $display("Reset test done");
  endtask : t_reset
  task automatic t_memory();
    drive(card_irq_pkg::CARD_MEMORY, 5'h10);
    expect_rd(8'h04, 32'h01);
    expect_rd(8'h04, 32'h00);
    drive(card_irq_pkg::CARD_MEMORY, 5'h18);
    expect_rd(8'h04, 32'h02);
    drive(card_irq_pkg::CARD_MEMORY, 5'h1C);
    expect_rd(8'h91, 32'h00);
    check(ext1(inta_n), 32'h1);
    reg_wr(8'h05, 32'h04);
    idle(2);
    check(ext1(inta_n), 32'h0);
    expect_rd(8'h04, 32'h04);
    idle(2);
    check(ext1(inta_n), 32'h1);
    pwr();
    expect_rd(8'h04, 32'h08);
    drive(card_irq_pkg::CARD_MEMORY, 5'h00);
    expect_rd(8'h04, 32'h07);
    reg_wr(8'h05, 32'h00);
    $display("Memory card test done");
  endtask : t_memory
  task automatic t_io();
    drive(card_irq_pkg::CARD_IO, 5'h04);
    expect_rd(8'h91, 32'h01);
    check(ext1(inta_n), 32'h0);
    expect_rd(8'h04, 32'h00);
    drive(card_irq_pkg::CARD_IO, 5'h14);
    expect_rd(8'h04, 32'h01);
    drive(card_irq_pkg::CARD_IO, 5'h00);
    expect_rd(8'h04, 32'h00);
    expect_rd(8'h91, 32'h00);
    check(ext1(inta_n), 32'h1);
    $display("I/O card test done");
  endtask : t_io
  task automatic t_cardbus();
    drive(card_irq_pkg::CARD_BUS, 5'h10);
    expect_rd(8'hA0, 32'h1);
    expect_rd(8'h04, 32'h0);
    reg_wr(8'hA0, 32'h1);
    expect_rd(8'hA0, 32'h0);
    drive(card_irq_pkg::CARD_BUS, 5'h13);
    expect_rd(8'hA0, 32'h6);
    expect_rd(8'h04, 32'h10);
    reg_wr(8'hA0, 32'h6);
    pwr();
    expect_rd(8'hA0, 32'h8);
    drive(card_irq_pkg::CARD_BUS, 5'h17);
    expect_rd(8'h91, 32'h1);
    check(ext1(inta_n), 32'h0);
    reg_wr(8'h92, 32'h08);
    idle(2);
    check({30'h0, intb_n, inta_n}, 32'h1);
    reg_wr(8'hA4, 32'h8);
    idle(2);
    check(ext1(inta_n), 32'h0);
    $display("CardBus test done");
  endtask : t_cardbus
  task automatic t_modes();
    reg_wr(8'h8C, 32'h52);
    reg_wr(8'h92, 32'h02);
    idle(2);
    check({25'h0, mp_o}, 32'h24);
    check({25'h0, mp_oe}, 32'h24);
    check(ext1(inta_n), 32'h0);
    reg_wr(8'h92, 32'h04);
    idle(2);
    check({30'h0, ser_csc, ser_func}, 32'h3);
    reg_wr(8'hA0, 32'h8);
    idle(2);
    check(ext1(ser_csc), 32'h0);
    reg_wr(8'h92, 32'h06);
    idle(2);
    check({30'h0, intb_n, inta_n}, 32'h3);
    reg_wr(8'h92, 32'h04);
    drive(card_irq_pkg::CARD_MEMORY, 5'h04);
    check(ext1(ser_func), 32'h0);
    reg_wr(8'h92, 32'h00);
    reg_wr(8'hA4, 32'h0);
    drive(card_irq_pkg::CARD_BUS, 5'h00);
    reg_wr(8'hA0, 32'hF);
    reg_rd(8'h04);
    $display("Signalling mode test done");
  endtask : t_modes
  task automatic t_clear_select();
    reg_wr(8'h1E, 32'h04);
    drive(card_irq_pkg::CARD_MEMORY, 5'h10);
    expect_rd(8'h04, 32'h01);
    expect_rd(8'h04, 32'h01);
    reg_wr(8'h04, 32'h01);
    expect_rd(8'h04, 32'h00);
    $display("Flag clear select test done");
  endtask : t_clear_select

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      test_done();
    end
  end

  initial begin
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_memory();
    t_io();
    t_cardbus();
    t_modes();
    t_clear_select();
    test_done();
  end
endmodule : tb_card_interrupt_events

bind card_interrupt_events card_interrupt_events_monitor checker_u (.CLK_SYS(CLK_SYS), .ARST_N(ARST_N),
  .CE(CE), .CARD_TYPE(CARD_TYPE), .REG_REQ(REG_REQ), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
  .PCI_INTA_N(PCI_INTA_N), .MULTIPURPOSE_PIN_O(MULTIPURPOSE_PIN_O), .MULTIPURPOSE_PIN_OE(MULTIPURPOSE_PIN_OE),
  .SERIAL_IRQ_CSC(SERIAL_IRQ_CSC), .SERIAL_IRQ_FUNC(SERIAL_IRQ_FUNC));
